/* pmpu_pkg.sv */
// Constants shared by the partitioned multiply and pack unit.
// Assumes a 64-bit operand path from the floating-point register file.
package pmpu_pkg;
    localparam int DATA_W = 64;
    localparam int LANE16_W = 16;
    localparam int LANE32_W = 32;
    localparam int BYTE_W = 8;
    localparam int PROD_W = 24;
    localparam int SCALE_W = 4;
    localparam int OP_W = 3;
    localparam int LANES16 = 4;
    localparam int LANES32 = 2;
    localparam int WIDE_LANES = 2;

    // Operation codes
    localparam logic [OP_W-1:0] OP_UPPER_BYTE_SIGNED_MUL = 3'h0;
    localparam logic [OP_W-1:0] OP_LOWER_BYTE_UNSIGNED_MUL = 3'h1;
    localparam logic [OP_W-1:0] OP_WIDE_UPPER_BYTE_MUL = 3'h2;
    localparam logic [OP_W-1:0] OP_WIDE_LOWER_BYTE_MUL = 3'h3;
    localparam logic [OP_W-1:0] OP_PACK_HALFWORD_TO_BYTE = 3'h4;
    localparam logic [OP_W-1:0] OP_PACK_WORD_TO_BYTE_SHIFT = 3'h5;
    localparam logic [OP_W-1:0] OP_LANE_ADD_HALFWORD = 3'h6;
    localparam logic [OP_W-1:0] OP_LANE_ADD_WORD = 3'h7;

    // Cycles from an accepted operation to its result
    localparam int LATENCY = 2;

    // Rounding constant for the top 16 of a 24-bit product
    localparam logic [PROD_W:0] MUL_ROUND = 25'h0000080;
    // Shift of the rounded upper product and of the word pack pass-through
    localparam int BYTE_SHIFT = 8;

    // Binary point positions of the pack operations
    localparam int PACK16_FRAC = 7;
    localparam int PACK32_FRAC = 23;

    localparam logic [BYTE_W-1:0] BYTE_MAX = 8'hFF;
    localparam logic [BYTE_W-1:0] BYTE_MIN = 8'h00;
endpackage

/* pmpu_pack_lane.sv */
// One scale, round and clamp lane of the pack operations.
// Assumes the scale amount and the lane value are stable within the cycle.
`timescale 1ns/1ps
module pmpu_pack_lane #(
    parameter int IN_W = 16,
    parameter int FRAC_W = 7,
    parameter bit DO_ROUND = 1'b1
) (
    input wire logic [IN_W-1:0] lane_in,
    input wire logic [pmpu_pkg::SCALE_W-1:0] scale,
    output logic [pmpu_pkg::BYTE_W-1:0] byte_out
);
    // Headroom for the largest shift plus the sign
    localparam int W = IN_W + 16;
    localparam logic [W-1:0] HALF = DO_ROUND ? (W'(1) << (FRAC_W - 1)) : '0;

    logic [W-1:0] ext;
    logic [W-1:0] shifted;
    logic [W-1:0] rounded;
    logic over;

    always_comb begin
        ext = {{16{lane_in[IN_W-1]}}, lane_in};
        shifted = ext << scale;
        rounded = shifted + HALF;
        over = |rounded[W-2:FRAC_W+pmpu_pkg::BYTE_W];
        if (rounded[W-1]) begin
            byte_out = pmpu_pkg::BYTE_MIN;
        end else if (over) begin
            byte_out = pmpu_pkg::BYTE_MAX;
        end else begin
            byte_out = rounded[FRAC_W+pmpu_pkg::BYTE_W-1:FRAC_W];
        end
    end
endmodule

/* pmpu_unit.sv */
// Partitioned byte-by-halfword multiply, lane add and pack datapath slice.
// Assumes operands arrive with op_valid from the pipeline on the core clock.
//
// Operation
// RL1: Upper multiply: signed high byte times signed 16-bit lane, four lanes.
// RL2: Upper multiply rounds the 24-bit product and keeps its top 16 bits.
// RL3: Lower multiply: unsigned low byte times the 16-bit lane, four lanes.
// RL4: Lower multiply sign-extends product to 32 bits, keeps upper 16 bits.
// RL5: Lower result sits 8 bits below upper; lane sum gives 16-bit product.
// RL6: Wide upper: signed high byte times lane, product shifted left 8.
// RL7: Wide lower: unsigned low byte times lane, product sign-extended to 32.
// RL8: Wide multiplies take two 16-bit lanes, give two 32-bit lanes.
// RL9: Halfword pack shifts four lanes by scale, rounds, drops low bits.
// RL10: Halfword pack clamps negative to zero and large values to 255.
// RL11: Word pack copies pass-through operand shifted left 8 bits.
// RL12: Word pack overwrites low byte of each 32-bit half with a lane byte.
// RL13: Word lanes shift by scale; binary point between bits 22 and 23.
// RL14: Word pack clamps negative to 0, above 255 to 255, else 8 bits.
// RL15: Pack scale is a 4-bit field taking every value 0 to 15.
// RL16: Lane adds wrap around with no overflow detection or saturation.
// RL17: Operation code selects the operation; result after fixed latency.
`timescale 1ns/1ps
module pmpu_unit (
    input wire logic clk,
    input wire logic nrst,
    input wire logic op_valid,
    input wire logic [pmpu_pkg::OP_W-1:0] op_code,
    input wire logic [pmpu_pkg::DATA_W-1:0] opnd_a,
    input wire logic [pmpu_pkg::DATA_W-1:0] opnd_b,
    input wire logic [pmpu_pkg::SCALE_W-1:0] graphics_status_reg_scale,
    output logic res_valid,
    output logic [pmpu_pkg::OP_W-1:0] res_op,
    output logic [pmpu_pkg::DATA_W-1:0] res_data
);
    // One-hot operation select, decoded on entry so that the result select
    // behind the multipliers is one and-or level rather than a full decode.
    typedef enum logic [7:0] {
        PMPU_SEL_UPPER = 8'h01,
        PMPU_SEL_LOWER = 8'h02,
        PMPU_SEL_WIDE_UPPER = 8'h04,
        PMPU_SEL_WIDE_LOWER = 8'h08,
        PMPU_SEL_PACK16 = 8'h10,
        PMPU_SEL_PACK32 = 8'h20,
        PMPU_SEL_ADD16 = 8'h40,
        PMPU_SEL_ADD32 = 8'h80
    } pmpu_sel_e;

    // Stage one holds the operation; stage two holds the result.
    logic s1_valid;
    pmpu_sel_e s1_sel;
    logic [pmpu_pkg::OP_W-1:0] s1_op;
    logic [pmpu_pkg::DATA_W-1:0] s1_a;
    logic [pmpu_pkg::DATA_W-1:0] s1_b;
    logic [pmpu_pkg::SCALE_W-1:0] s1_scale;

    logic next_s1_valid;
    pmpu_sel_e next_s1_sel;
    logic [pmpu_pkg::OP_W-1:0] next_s1_op;
    logic [pmpu_pkg::DATA_W-1:0] next_s1_a;
    logic [pmpu_pkg::DATA_W-1:0] next_s1_b;
    logic [pmpu_pkg::SCALE_W-1:0] next_s1_scale;

    logic next_res_valid;
    logic [pmpu_pkg::OP_W-1:0] next_res_op;
    logic [pmpu_pkg::DATA_W-1:0] next_res_data;

    // Per-operation results of stage two
    logic [pmpu_pkg::DATA_W-1:0] upper_res;
    logic [pmpu_pkg::DATA_W-1:0] lower_res;
    logic [pmpu_pkg::DATA_W-1:0] wide_upper_res;
    logic [pmpu_pkg::DATA_W-1:0] wide_lower_res;
    logic [pmpu_pkg::DATA_W-1:0] pack16_res;
    logic [pmpu_pkg::DATA_W-1:0] pack32_res;
    logic [pmpu_pkg::DATA_W-1:0] add16_res;
    logic [pmpu_pkg::DATA_W-1:0] add32_res;
    logic [pmpu_pkg::BYTE_W*pmpu_pkg::LANES16-1:0] pack16_bytes;
    logic [pmpu_pkg::BYTE_W*pmpu_pkg::LANES32-1:0] pack32_bytes;

    // Signed high byte times signed lane, 24-bit product
    function automatic logic [pmpu_pkg::PROD_W-1:0] prod_hi(
        input logic [pmpu_pkg::LANE16_W-1:0] a,
        input logic [pmpu_pkg::LANE16_W-1:0] b
    );
        logic signed [pmpu_pkg::PROD_W-1:0] hi;
        logic signed [pmpu_pkg::PROD_W-1:0] p;
        hi = 24'($signed(a[15:8]));
        p = hi * 24'($signed(b)); // RL1
        return p;
    endfunction

    // Unsigned low byte times signed lane; the zero pad keeps the byte unsigned
    function automatic logic [pmpu_pkg::PROD_W-1:0] prod_lo(
        input logic [pmpu_pkg::LANE16_W-1:0] a,
        input logic [pmpu_pkg::LANE16_W-1:0] b
    );
        logic signed [pmpu_pkg::PROD_W-1:0] lo;
        logic signed [pmpu_pkg::PROD_W-1:0] p;
        lo = 24'({1'b0, a[7:0]});
        p = lo * 24'($signed(b)); // RL3
        return p;
    endfunction

    // Round to the top 16 bits of the product
    function automatic logic [pmpu_pkg::LANE16_W-1:0] round_top(
        input logic [pmpu_pkg::PROD_W-1:0] p
    );
        logic [pmpu_pkg::PROD_W:0] r;
        r = {p[pmpu_pkg::PROD_W-1], p} + pmpu_pkg::MUL_ROUND;
        return r[pmpu_pkg::PROD_W-1:pmpu_pkg::BYTE_SHIFT]; // RL2
    endfunction

    // Upper 16 bits of the sign-extended product; no rounding, so the pair
    // of partial results keeps the 8-bit offset between them.
    function automatic logic [pmpu_pkg::LANE16_W-1:0] ext_top(
        input logic [pmpu_pkg::PROD_W-1:0] p
    );
        logic [pmpu_pkg::LANE32_W-1:0] e;
        e = {{8{p[pmpu_pkg::PROD_W-1]}}, p}; // RL4
        return e[pmpu_pkg::LANE32_W-1:pmpu_pkg::LANE16_W]; // RL5
    endfunction

    // Input stage: operands load only with op_valid, so idle cycles
    // leave the multiplier inputs still
    always_comb begin
        next_s1_valid = op_valid;
        next_s1_sel = s1_sel;
        next_s1_op = s1_op;
        next_s1_a = s1_a;
        next_s1_b = s1_b;
        next_s1_scale = s1_scale;
        if (op_valid) begin
            next_s1_op = op_code; // RL17
            next_s1_a = opnd_a;
            next_s1_b = opnd_b;
            next_s1_scale = graphics_status_reg_scale; // RL15
            case (op_code) // RL17
                pmpu_pkg::OP_UPPER_BYTE_SIGNED_MUL: begin
                    next_s1_sel = PMPU_SEL_UPPER;
                end
                pmpu_pkg::OP_LOWER_BYTE_UNSIGNED_MUL: begin
                    next_s1_sel = PMPU_SEL_LOWER;
                end
                pmpu_pkg::OP_WIDE_UPPER_BYTE_MUL: begin
                    next_s1_sel = PMPU_SEL_WIDE_UPPER;
                end
                pmpu_pkg::OP_WIDE_LOWER_BYTE_MUL: begin
                    next_s1_sel = PMPU_SEL_WIDE_LOWER;
                end
                pmpu_pkg::OP_PACK_HALFWORD_TO_BYTE: begin
                    next_s1_sel = PMPU_SEL_PACK16;
                end
                pmpu_pkg::OP_PACK_WORD_TO_BYTE_SHIFT: begin
                    next_s1_sel = PMPU_SEL_PACK32;
                end
                pmpu_pkg::OP_LANE_ADD_HALFWORD: begin
                    next_s1_sel = PMPU_SEL_ADD16;
                end
                pmpu_pkg::OP_LANE_ADD_WORD: begin
                    next_s1_sel = PMPU_SEL_ADD32;
                end
                default: begin
                    next_s1_sel = PMPU_SEL_UPPER;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_valid <= 1'b0;
            s1_sel <= PMPU_SEL_UPPER;
            s1_op <= pmpu_pkg::OP_UPPER_BYTE_SIGNED_MUL;
            s1_a <= '0;
            s1_b <= '0;
            s1_scale <= '0;
        end else begin
            s1_valid <= next_s1_valid;
            s1_sel <= next_s1_sel;
            s1_op <= next_s1_op;
            s1_a <= next_s1_a;
            s1_b <= next_s1_b;
            s1_scale <= next_s1_scale;
        end
    end

    // Four halfword lanes: partitioned multiplies and the wrapping add
    genvar i;
    generate
        for (i = 0; i < pmpu_pkg::LANES16; i++) begin : g_h
            logic [pmpu_pkg::LANE16_W-1:0] la;
            logic [pmpu_pkg::LANE16_W-1:0] lb;
            assign la = s1_a[i*16 +: 16];
            assign lb = s1_b[i*16 +: 16];
            assign upper_res[i*16 +: 16] = round_top(prod_hi(la, lb)); // RL2
            assign lower_res[i*16 +: 16] = ext_top(prod_lo(la, lb)); // RL4
            assign add16_res[i*16 +: 16] = la + lb; // RL16
            pmpu_pack_lane #(
                .IN_W(pmpu_pkg::LANE16_W),
                .FRAC_W(pmpu_pkg::PACK16_FRAC),
                .DO_ROUND(1'b1)
            ) u_pack16 (
                .lane_in(lb),
                .scale(s1_scale),
                .byte_out(pack16_bytes[i*8 +: 8])
            ); // RL9 RL10
        end
    endgenerate

    // Wide multiplies read the low 32 bits: two 16-bit lanes in, two 32-bit out
    generate
        for (i = 0; i < pmpu_pkg::WIDE_LANES; i++) begin : g_w
            logic [pmpu_pkg::LANE16_W-1:0] wa;
            logic [pmpu_pkg::LANE16_W-1:0] wb;
            logic [pmpu_pkg::PROD_W-1:0] ph;
            logic [pmpu_pkg::PROD_W-1:0] pl;
            assign wa = s1_a[i*16 +: 16];
            assign wb = s1_b[i*16 +: 16];
            assign ph = prod_hi(wa, wb); // RL6
            assign pl = prod_lo(wa, wb); // RL7
            assign wide_upper_res[i*32 +: 32] = {ph, 8'h00}; // RL6 RL8
            assign wide_lower_res[i*32 +: 32] = {{8{pl[23]}}, pl}; // RL7 RL8
        end
    endgenerate

    // Two word lanes: word pack and the wrapping word add
    generate
        for (i = 0; i < pmpu_pkg::LANES32; i++) begin : g_d
            assign add32_res[i*32 +: 32] = s1_a[i*32 +: 32] + s1_b[i*32 +: 32]; // RL16
            pmpu_pack_lane #(
                .IN_W(pmpu_pkg::LANE32_W),
                .FRAC_W(pmpu_pkg::PACK32_FRAC),
                .DO_ROUND(1'b0)
            ) u_pack32 (
                .lane_in(s1_b[i*32 +: 32]),
                .scale(s1_scale),
                .byte_out(pack32_bytes[i*8 +: 8])
            ); // RL13 RL14
        end
    endgenerate

    // Halfword pack fills the low word; the upper word reads zero
    assign pack16_res = {32'h00000000, pack16_bytes};

    // Byte shifted out of the top of each half is dropped by design
    always_comb begin
        pack32_res = s1_a << pmpu_pkg::BYTE_SHIFT; // RL11
        pack32_res[7:0] = pack32_bytes[7:0]; // RL12
        pack32_res[39:32] = pack32_bytes[15:8]; // RL12
    end

    // Result select and output stage
    // Data and op code hold between results; only the valid flag pulses
    always_comb begin
        next_res_valid = s1_valid;
        next_res_op = res_op;
        next_res_data = res_data;
        if (s1_valid) begin
            next_res_op = s1_op;
            case (s1_sel) // RL17
                PMPU_SEL_UPPER: begin
                    next_res_data = upper_res;
                end
                PMPU_SEL_LOWER: begin
                    next_res_data = lower_res;
                end
                PMPU_SEL_WIDE_UPPER: begin
                    next_res_data = wide_upper_res;
                end
                PMPU_SEL_WIDE_LOWER: begin
                    next_res_data = wide_lower_res;
                end
                PMPU_SEL_PACK16: begin
                    next_res_data = pack16_res;
                end
                PMPU_SEL_PACK32: begin
                    next_res_data = pack32_res;
                end
                PMPU_SEL_ADD16: begin
                    next_res_data = add16_res;
                end
                PMPU_SEL_ADD32: begin
                    next_res_data = add32_res;
                end
                default: begin
                    next_res_data = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            res_valid <= 1'b0;
            res_op <= pmpu_pkg::OP_UPPER_BYTE_SIGNED_MUL;
            res_data <= '0;
        end else begin
            res_valid <= next_res_valid;
            res_op <= next_res_op;
            res_data <= next_res_data;
        end
    end
endmodule

/* pmpu_unit_monitor.sv */
// Port-level checks of the partitioned multiply and pack unit.
// Assumes it is bound to pmpu_unit and sees only its ports.
`timescale 1ns/1ps
module pmpu_unit_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [63:0] opnd_a,
    input wire logic [63:0] opnd_b,
    input wire logic [3:0] graphics_status_reg_scale,
    input wire logic res_valid,
    input wire logic [2:0] res_op,
    input wire logic [63:0] res_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    lat_fwd_a: assert property (op_valid |-> ##2 res_valid) else $error("result missing");
    lat_back_a: assert property (res_valid |-> $past(op_valid, 2)) else $error("stray result");
    res_op_a: assert property (res_valid |-> res_op == $past(op_code, 2)) else $error("op tag");
    rst_clr_a: assert property (disable iff (1'b0) !nrst |=> !res_valid && res_data == 64'h0)
        else $error("reset state");
    hold_a: assert property (!res_valid && $past(nrst) |-> $stable(res_data)) else $error("hold");
    pk16_hi_a: assert property (res_valid && res_op == 3'h4 |-> res_data[63:32] == 32'h0)
        else $error("pack16 upper half");
    pk32_pass_a: assert property (res_valid && res_op == 3'h5 |->
        res_data[31:8] == $past(opnd_a[23:0], 2) && res_data[63:40] == $past(opnd_a[55:32], 2))
        else $error("pack32 pass-through");
    wide_hi_a: assert property (res_valid && res_op == 3'h2 |->
        res_data[7:0] == 8'h00 && res_data[39:32] == 8'h00) else $error("wide upper shift");
    wide_lo_a: assert property (res_valid && res_op == 3'h3 |->
        res_data[31:24] == {8{res_data[23]}}) else $error("wide lower sign");
    add_wrap_a: assert property (res_valid && res_op == 3'h6 |->
        res_data[15:0] == $past(opnd_a[15:0], 2) + $past(opnd_b[15:0], 2)) else $error("add wrap");
endmodule
bind pmpu_unit pmpu_unit_monitor u_pmpu_unit_monitor (.clk(clk), .nrst(nrst), .op_valid(op_valid),
    .op_code(op_code), .opnd_a(opnd_a), .opnd_b(opnd_b),
    .graphics_status_reg_scale(graphics_status_reg_scale), .res_valid(res_valid),
    .res_op(res_op), .res_data(res_data));

/* pmpu_regfile_model.sv */
// Register file write-back side: logs every result the unit returns.
// Assumes one write per res_valid cycle, no back-pressure.
`timescale 1ns/1ps
module pmpu_regfile_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic res_valid,
    input wire logic [63:0] res_data,
    output int wb_cnt
);
    logic [63:0] wb [0:255];
    always @(posedge clk) begin
        if (!nrst) begin
            wb_cnt <= 0;
        end else if (res_valid) begin
            wb[wb_cnt[7:0]] <= res_data;
            wb_cnt <= wb_cnt + 1;
        end
    end
endmodule

/* pmpu_unit_bench.sv */
// Self-checking bench of the partitioned multiply and pack unit.
// Assumes the two-cycle result latency of the unit.
`timescale 1ns/1ps
module pmpu_unit_bench;
    logic clk = 0, nrst = 0, op_valid = 0, res_valid;
    logic [2:0] op_code = 0, res_op;
    logic [63:0] opnd_a = 0, opnd_b = 0, res_data, g, e;
    logic [3:0] scale = 0;
    int wb_cnt, error_cnt = 0, num_checks = 0, k;
    always #2.5 clk = ~clk;
    pmpu_unit u_pmpu_unit (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
        .opnd_a(opnd_a), .opnd_b(opnd_b), .graphics_status_reg_scale(scale),
        .res_valid(res_valid), .res_op(res_op), .res_data(res_data));
    pmpu_regfile_model u_pmpu_regfile_model (.clk(clk), .nrst(nrst), .res_valid(res_valid),
        .res_data(res_data), .wb_cnt(wb_cnt));
    // Clamp a scaled value whose binary point sits right of bit f
    function automatic logic [7:0] clamp(input longint v, input int f);
        if (v < 0) return 8'h00;
        return ((v >>> f) > 255) ? 8'hFF : 8'((v >>> f));
    endfunction
    function automatic logic [63:0] ref_res(input logic [2:0] op, input logic [63:0] a, b,
        input logic [3:0] s);
        logic [63:0] r;
        logic signed [23:0] p;
        r = 64'h0;
        for (int i = 0; i < 4; i++) begin
            if (op == 3'h0 || op == 3'h2) p = $signed(a[16*i+8+:8]) * $signed(b[16*i+:16]);
            else p = $signed({1'b0, a[16*i+:8]}) * $signed(b[16*i+:16]);
            case (op)
                3'h0: r[16*i+:16] = 16'((p + 24'sh80) >>> 8);
                3'h1: r[16*i+:16] = {{8{p[23]}}, p[23:16]};
                3'h2: if (i < 2) r[32*i+:32] = {p, 8'h00};
                3'h3: if (i < 2) r[32*i+:32] = {{8{p[23]}}, p};
                3'h4: r[8*i+:8] = clamp((longint'($signed(b[16*i+:16])) <<< s) + 64, 7);
                3'h6: r[16*i+:16] = a[16*i+:16] + b[16*i+:16];
                default: ;
            endcase
        end
        if (op == 3'h5) begin
            r = a << 8;
            for (int j = 0; j < 2; j++) r[32*j+:8] = clamp(longint'($signed(b[32*j+:32])) <<< s, 23);
        end
        if (op == 3'h7) r = {a[63:32] + b[63:32], a[31:0] + b[31:0]};
        return r;
    endfunction
    task check(input string name, input logic [63:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task t_op(input logic [2:0] op, input logic [63:0] a, b, input logic [3:0] s);
        int n;
        n = 0;
        e = ref_res(op, a, b, s);
        @(posedge clk); #1;
        op_valid = 1; op_code = op; opnd_a = a; opnd_b = b; scale = s;
        @(posedge clk); #1;
        op_valid = 0; opnd_a = ~a; opnd_b = ~b;
        while (res_valid !== 1'b1 && n < 4) begin
            @(posedge clk); #1; n++;
        end
        g = res_data;
        check("latency", 64'(n), 64'd1);
        check("res_op", {61'h0, res_op}, {61'h0, op});
    endtask
    task t_mul;
        logic [63:0] u, l;
        t_op(3'h0, 64'h8001_7FFF_12F3_FF80, 64'h7FFF_8000_0123_FFFF, 0); u = g;
        check("upper mul", g, e);
        t_op(3'h1, 64'h8001_7FFF_12F3_FF80, 64'h7FFF_8000_0123_FFFF, 0); l = g;
        check("lower mul", g, e);
        t_op(3'h6, u, l, 0);
        check("lane sum", g, e);
        $display("test mul done");
    endtask
    task t_wide;
        logic [63:0] u;
        logic [31:0] a, b;
        a = 32'h8123_7F05; b = 32'hFF01_8000;
        t_op(3'h2, {32'h0, a}, {32'h0, b}, 0); u = g;
        check("wide upper", g, e);
        t_op(3'h3, {32'h0, a}, {32'h0, b}, 0);
        check("wide lower", g, e);
        t_op(3'h7, u, g, 0);
        check("wide product", g, {int'($signed(a[31:16])) * int'($signed(b[31:16])),
            int'($signed(a[15:0])) * int'($signed(b[15:0]))});
        $display("test wide done");
    endtask
    task t_pack;
        for (k = 0; k < 16; k++) begin
            t_op(3'h4, 64'h0, 64'h8000_0040_0123_7FFF, k[3:0]);
            check("pack halfword", g, e);
            t_op(3'h5, 64'h1122_3344_5566_7788, 64'hFFF0_0000_0001_2345, k[3:0]);
            check("pack word", g, e);
        end
        $display("test pack done");
    endtask
    task t_b2b;
        int c0;
        logic [63:0] x [4];
        @(posedge clk); #1;
        c0 = wb_cnt;
        op_valid = 1;
        for (k = 0; k < 4; k++) begin
            op_code = k[2:0]; opnd_a = 64'hA5C3_1234_8001_FF7F + k; opnd_b = 64'h7001_8FFF_00F0_1357;
            x[k] = ref_res(k[2:0], opnd_a, opnd_b, 0);
            @(posedge clk); #1;
        end
        op_valid = 0;
        repeat (4) @(posedge clk);
        #1;
        check("b2b count", 64'(wb_cnt - c0), 64'd4);
        for (k = 0; k < 4; k++) check("b2b result", u_pmpu_regfile_model.wb[8'(c0 + k)], x[k]);
        $display("test back-to-back done");
    endtask
    task t_reset;
        @(posedge clk); #1;
        op_valid = 1; op_code = 3'h6; opnd_a = 64'h7FFF_7FFF_FFFF_0001;
        @(posedge clk); #1;
        op_valid = 0; nrst = 0;
        @(posedge clk);
        #1;
        check("reset valid", {63'h0, res_valid}, 64'h0);
        check("reset data", res_data, 64'h0);
        check("reset op", {61'h0, res_op}, 64'h0);
        @(posedge clk);
        #1;
        nrst = 1;
        $display("test reset done");
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1;
        nrst = 1;
        t_mul;
        t_wide;
        t_pack;
        t_b2b;
        t_reset;
        t_mul;
        print_verdict;
    end
    // Generous span: the tests need well under a thousand cycles
    initial begin
        #20000;
        error_cnt++;
        print_verdict;
    end
endmodule
